// file: hw/clk_half.sv
// divide-by-two stage and machine-cycle phase counter
`include "irq_pm_defines.svh"
module clk_half (
   // clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // run control
   input  wire logic       osc_run,
   // timing outputs
   output logic            phase_tick,
   output logic [3:0]      phase_idx,
   output logic            mc_end
);
   logic half_q;

   // ------------------------------------------------------------
   // divider
   // ------------------------------------------------------------
   // toggle flop makes tick rate independent of input duty cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         half_q <= 1'b0;
      end else if (osc_run) begin
         half_q <= ~half_q;
      end
   end

   assign phase_tick = osc_run & half_q;
   assign mc_end     = phase_tick && (phase_idx == `PHASES_PER_MC - 4'd1);

   // phase counter, twelve phases to a machine cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         phase_idx <= 4'h0;
      end else if (mc_end) begin
         phase_idx <= 4'h0;
      end else if (phase_tick) begin
         phase_idx <= phase_idx + 4'h1;
      end
   end
endmodule

// file: hw/edge_sync.sv
// three-stage synchroniser with falling edge detection
module edge_sync (
   // clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // pin and results
   input  wire logic pin,
   output logic      level,
   output logic      fall
);
   logic [2:0] sync_q;
   logic       level_q;

   // ------------------------------------------------------------
   // sync chain
   // ------------------------------------------------------------
   // resets high: pins idle high, avoids a false edge at release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync_q  <= 3'h7;
         level_q <= 1'b1;
      end else begin
         sync_q <= {sync_q[1:0], pin};
         if (sync_q[1] == sync_q[2]) begin
            level_q <= sync_q[2];
         end
      end
   end

   assign level = level_q;
   assign fall  = level_q & (sync_q[1] == sync_q[2]) & ~sync_q[2];
endmodule

// file: hw/irq_pm_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef IRQ_PM_DEFINES_SVH
`define IRQ_PM_DEFINES_SVH

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define OFS_INTERRUPT_ENABLE 8'h00
`define OFS_POWER_CTRL       8'h04
`define OFS_FLAGS            8'h08
`define OFS_STATUS           8'h0C

// ------------------------------------------------------------
// interrupt_enable fields
// ------------------------------------------------------------
`define IE_EXT0_BIT   0
`define IE_T0_BIT     1
`define IE_EXT1_BIT   2
`define IE_T1_BIT     3
`define IE_SER_BIT    4
`define IE_T2_BIT     5
`define IE_RSVD_BIT   6
`define IE_GLOBAL_BIT 7
`define IE_RESET      8'h00
`define IE_WR_MASK    8'hBF

// ------------------------------------------------------------
// flag register fields
// ------------------------------------------------------------
`define FL_T0_BIT     0
`define FL_T1_BIT     1
`define FL_T2OV_BIT   2
`define FL_T2EV_BIT   3
`define FL_T2TRIG_BIT 4

// ------------------------------------------------------------
// power control fields
// ------------------------------------------------------------
`define PC_IDLE_BIT   0
`define PC_PDOWN_BIT  1

// ------------------------------------------------------------
// timing: machine cycle of 6 states x 2 phases on the halved clock
// ------------------------------------------------------------
`define PHASES_PER_MC  4'd12
`define PH_S2P2        4'd3
`define PH_S5P2        4'd9
`define RST_GUARD_MC   2'd2

`endif

// file: hw/irq_pm_pkg.sv
// types shared by the interrupt and power mode block
package irq_pm_pkg;
   typedef enum logic [2:0] {
      PM_RUN   = 3'b001,
      PM_IDLE  = 3'b010,
      PM_PDOWN = 3'b100
   } pm_state_t;
endpackage

// file: hw/irq_pm_top.sv
// interrupt gating and idle / power-down control behind an AHB-Lite slave
//
// The implementer's own choices: the AHB-Lite register port and the register offsets.
`include "irq_pm_defines.svh"

// Contract
// - six request sources: two pins, timers 0, 1, 2, serial, each own line
// - each source has its own enable bit in interrupt_enable
// - bit 7 global enable; zero blocks every request
// - bit map: 5 t2, 4 serial, 3 t1, 2 ext1, 1 t0, 0 ext0
// - timer 2 request is overflow flag OR event flag
// - timer 2 flags stay set on entry; software clears them
// - timer 0/1 flags set at S5P2, polled next machine cycle; here latched at the end of the same machine cycle
// - timer 2 overflow flag set at S2P2, polled same cycle
// - input clock halved by a toggle flop before internal timing
// - idle halts cpu, peripherals run, registers hold
// - idle ends on enabled request or hardware reset
// - reset out of idle: ram writes blocked two machine cycles, ports not
// - idle drives ALE/strobe high, power-down low; port 0/2 per mode
// - power-down stops oscillator, nothing executes, registers kept
// - power-down exits only by hardware reset
// - trigger enabled: falling trigger pin edge sets timer 2 event flag
module irq_pm_top
   import irq_pm_pkg::*;
(
   // clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // request sources
   input  wire logic        ext_irq_pin_a,
   input  wire logic        ext_irq_pin_b,
   input  wire logic        timer0_ovf,
   input  wire logic        timer1_ovf,
   input  wire logic        timer2_ovf,
   input  wire logic        serial_req,
   input  wire logic        timer2_trigger_pin,
   // cpu side
   input  wire logic        irq_ack,
   input  wire logic        ext_program_mem,
   output logic [5:0]       irq_req,
   output logic             cpu_halt,
   output logic             ram_write_block,
   output logic             osc_stop,
   // pin state during low power
   output logic             ale_out,
   output logic             program_store_strobe,
   output logic             port0_float,
   output logic             port2_address
);
   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [7:0]  interrupt_enable_q;
   logic [4:0]  flags_q;
   logic [5:0]  irq_req_q;
   pm_state_t   pm_q;
   logic        halt_q, rblk_q, osc_q, ale_q, pss_q, p0f_q, p2a_q;
   logic [1:0]  guard_q;
   logic        wr_pend_q;
   logic [7:0]  wr_addr_q;
   logic [31:0] rdata_q;
   logic        phase_tick, mc_end;
   logic [3:0]  phase_idx;
   logic        ext_a_lvl, ext_b_lvl, trig_fall;
   logic        t0_pend_q, t1_pend_q, t2_pend_q;
   logic [5:0]  src_flag, src_gate;
   logic        addr_ok;
   logic [7:0]  wbyte;
   logic        t2_req;

   // ------------------------------------------------------------
   // timing and synchronisers
   // ------------------------------------------------------------
   // oscillator stops in power-down, so phase counter freezes
   clk_half u_half (
      .hclk       (hclk),
      .hresetn    (hresetn),
      .osc_run    (~osc_q),
      .phase_tick (phase_tick),
      .phase_idx  (phase_idx),
      .mc_end     (mc_end)
   );

   edge_sync u_ext_a (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (ext_irq_pin_a),
      .level   (ext_a_lvl),
      .fall    ()
   );

   edge_sync u_ext_b (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (ext_irq_pin_b),
      .level   (ext_b_lvl),
      .fall    ()
   );

   edge_sync u_trig (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (timer2_trigger_pin),
      .level   (),
      .fall    (trig_fall)
   );

   // ------------------------------------------------------------
   // ahb-lite slave
   // ------------------------------------------------------------
   assign addr_ok = hsel & hready & htrans[1];
   assign wbyte   = hwdata[7:0];

   // capture write address phase; zero wait states
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
      end else begin
         wr_pend_q <= addr_ok & hwrite;
         wr_addr_q <= haddr;
      end
   end

   // read data registered from the address phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (addr_ok & ~hwrite) begin
         case (haddr)
            `OFS_INTERRUPT_ENABLE: rdata_q <= {24'h000000, interrupt_enable_q};
            `OFS_POWER_CTRL:       rdata_q <= {30'h0, pm_q == PM_PDOWN, pm_q == PM_IDLE};
            `OFS_FLAGS:            rdata_q <= {27'h0, flags_q};
            `OFS_STATUS:           rdata_q <= {24'h0, ext_b_lvl, ext_a_lvl, irq_req_q};
            default:               rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   assign hrdata    = rdata_q;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // enable register; bit 6 has no storage so a stray one is dropped
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         interrupt_enable_q <= `IE_RESET;
      end else if (wr_pend_q && wr_addr_q == `OFS_INTERRUPT_ENABLE) begin
         interrupt_enable_q <= wbyte & `IE_WR_MASK;
      end
   end

   // ------------------------------------------------------------
   // source flags
   // ------------------------------------------------------------
   // overflow events wait for their set phase; set beats software clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags_q   <= 5'h00;
         t0_pend_q <= 1'b0;
         t1_pend_q <= 1'b0;
         t2_pend_q <= 1'b0;
      end else begin
         logic [4:0] nxt;
         nxt = flags_q;
         if (wr_pend_q && wr_addr_q == `OFS_FLAGS) begin
            nxt = wbyte[4:0] & 5'h1F; // software writes flags and trigger enable
         end
         t0_pend_q <= (t0_pend_q | timer0_ovf) & ~(phase_tick && phase_idx == `PH_S5P2);
         t1_pend_q <= (t1_pend_q | timer1_ovf) & ~(phase_tick && phase_idx == `PH_S5P2);
         if (phase_tick && phase_idx == `PH_S5P2) begin
            if (t0_pend_q | timer0_ovf) nxt[`FL_T0_BIT] = 1'b1;
            if (t1_pend_q | timer1_ovf) nxt[`FL_T1_BIT] = 1'b1;
         end
         // timer 2 waits for its own earlier set phase, so it is still polled in that cycle
         t2_pend_q <= (t2_pend_q | timer2_ovf) & ~(phase_tick && phase_idx == `PH_S2P2);
         if (phase_tick && phase_idx == `PH_S2P2 && (t2_pend_q | timer2_ovf)) begin
            nxt[`FL_T2OV_BIT] = 1'b1;
         end
         if (trig_fall && flags_q[`FL_T2TRIG_BIT]) begin
            nxt[`FL_T2EV_BIT] = 1'b1;
         end
         flags_q <= nxt; // no clear on acknowledge
      end
   end

   // ------------------------------------------------------------
   // request gating
   // ------------------------------------------------------------
   assign t2_req = flags_q[`FL_T2OV_BIT] | flags_q[`FL_T2EV_BIT];
   // pins are active low; serial request is a level from the port
   assign src_flag = {t2_req, serial_req, flags_q[`FL_T1_BIT], ~ext_b_lvl,
                      flags_q[`FL_T0_BIT], ~ext_a_lvl};
   assign src_gate = src_flag & interrupt_enable_q[5:0]
                     & {6{interrupt_enable_q[`IE_GLOBAL_BIT]}};

   // timer 0/1 and timer 2 all seen at the end of the cycle their flag is set in
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req_q <= 6'h00;
      end else begin
         if (mc_end) begin
            irq_req_q <= src_gate;
         end else if (!interrupt_enable_q[`IE_GLOBAL_BIT]) begin
            irq_req_q <= 6'h00;
         end
      end
   end
   assign irq_req = irq_req_q;

   // ------------------------------------------------------------
   // power mode state
   // ------------------------------------------------------------
   // idle or power-down entry from power control; only reset leaves power-down
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pm_q <= PM_RUN;
      end else begin
         case (pm_q)
            PM_RUN: begin
               if (wr_pend_q && wr_addr_q == `OFS_POWER_CTRL) begin
                  if (wbyte[`PC_PDOWN_BIT]) pm_q <= PM_PDOWN;
                  else if (wbyte[`PC_IDLE_BIT]) pm_q <= PM_IDLE;
               end
            end
            PM_IDLE: begin
               if (|src_gate) pm_q <= PM_RUN;
            end
            PM_PDOWN: pm_q <= PM_PDOWN;
            default:  pm_q <= PM_RUN;
         endcase
      end
   end

   // registered mode outputs; idle keeps peripherals clocked
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_q <= 1'b0;
         osc_q  <= 1'b0;
         ale_q  <= 1'b1;
         pss_q  <= 1'b1;
         p0f_q  <= 1'b0;
         p2a_q  <= 1'b0;
      end else begin
         halt_q <= (pm_q != PM_RUN);
         osc_q  <= (pm_q == PM_PDOWN);
         ale_q  <= (pm_q != PM_PDOWN);
         pss_q  <= (pm_q != PM_PDOWN);
         p0f_q  <= (pm_q != PM_RUN) & ext_program_mem;
         p2a_q  <= (pm_q == PM_IDLE) & ext_program_mem;
      end
   end

   // ram write guard after a reset; counts two halved-clock machine cycles
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         guard_q <= `RST_GUARD_MC;
         rblk_q  <= 1'b1;
      end else begin
         if (mc_end && guard_q != 2'd0) guard_q <= guard_q - 2'd1;
         rblk_q <= (guard_q != 2'd0) | (pm_q != PM_RUN);
      end
   end

   assign cpu_halt             = halt_q;
   assign osc_stop             = osc_q;
   assign ram_write_block      = rblk_q;
   assign ale_out              = ale_q;
   assign program_store_strobe = pss_q;
   assign port0_float          = p0f_q;
   assign port2_address        = p2a_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   global_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
      !interrupt_enable_q[`IE_GLOBAL_BIT] |=> irq_req_q == 6'h00)
      else $error("request raised with global enable low");
   rsvd_bit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      interrupt_enable_q[`IE_RSVD_BIT] == 1'b0)
      else $error("reserved enable bit set");
   t2_or_a: assert property (@(posedge hclk) disable iff (!hresetn)
      mc_end && interrupt_enable_q[7] && interrupt_enable_q[5] && t2_req |=> irq_req_q[5])
      else $error("timer 2 request missing");
   t2_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
      irq_ack && flags_q[`FL_T2OV_BIT] && !(wr_pend_q && wr_addr_q == `OFS_FLAGS)
      |=> flags_q[`FL_T2OV_BIT])
      else $error("timer 2 flag cleared by hardware");
   t0_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
      $rose(flags_q[`FL_T0_BIT]) |-> $past(phase_idx) == `PH_S5P2
      || $past(wr_pend_q))
      else $error("timer 0 flag set off phase");
   pdown_stay_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pm_q == PM_PDOWN |=> pm_q == PM_PDOWN)
      else $error("power-down left without reset");
   pdown_pins_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pm_q == PM_PDOWN |=> !ale_out && !program_store_strobe && osc_stop)
      else $error("power-down pin state wrong");
   idle_exit_a: assert property (@(posedge hclk) disable iff (!hresetn)
      pm_q == PM_IDLE && |src_gate |=> pm_q == PM_RUN ##1 !cpu_halt)
      else $error("idle not left on request");
endmodule

// file: verification/src_model.sv
// model of the peripheral request sources and pins that feed the interrupt block
module src_model (
   // clock
   input  wire logic hclk,
   // request lines
   output logic      pin_a,
   output logic      pin_b,
   output logic      t0_ovf,
   output logic      t1_ovf,
   output logic      t2_ovf,
   output logic      ser_req,
   output logic      trig_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   // pins idle high (pulled up), pulses and serial level idle low
   initial begin
      pin_a    = 1'b1;
      pin_b    = 1'b1;
      t0_ovf   = 1'b0;
      t1_ovf   = 1'b0;
      t2_ovf   = 1'b0;
      ser_req  = 1'b0;
      trig_pin = 1'b1;
   end

   // raise source i in enable-bit order: ext0, t0, ext1, t1, serial, t2
   task automatic raise(input int i);
      @(posedge hclk);
      case (i)
         0: pin_a <= 1'b0;
         1: t0_ovf <= 1'b1;
         2: pin_b <= 1'b0;
         3: t1_ovf <= 1'b1;
         4: ser_req <= 1'b1;
         default: t2_ovf <= 1'b1;
      endcase
      // timer overflows are single-cycle pulses, never levels
      @(posedge hclk);
      t0_ovf <= 1'b0;
      t1_ovf <= 1'b0;
      t2_ovf <= 1'b0;
   endtask

   // release every level request
   task automatic drop_all;
      @(posedge hclk);
      pin_a   <= 1'b1;
      pin_b   <= 1'b1;
      ser_req <= 1'b0;
   endtask

   // falling edge on the trigger pin, held low long enough for the synchroniser
   task automatic trig_fall;
      @(posedge hclk);
      trig_pin <= 1'b0;
      repeat (6) @(posedge hclk);
      trig_pin <= 1'b1;
   endtask
endmodule

// file: verification/tb_top.sv
// self-checking testbench for the interrupt gating and power mode block
`include "irq_pm_defines.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic        hclk, hresetn, hsel, hwrite, irq_ack, ext_program_mem;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rdata;
   logic        hreadyout, hresp, cpu_halt, ram_write_block, osc_stop;
   logic        ale_out, program_store_strobe, port0_float, port2_address;
   logic [5:0]  irq_req;
   logic        pin_a, pin_b, t0, t1, t2, ser, trig;
   int          n_fail, cmp_count;

   irq_pm_top u_irq_pm_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
      .timer0_ovf(t0), .timer1_ovf(t1), .timer2_ovf(t2), .serial_req(ser), .timer2_trigger_pin(trig),
      .irq_ack(irq_ack), .ext_program_mem(ext_program_mem), .irq_req(irq_req), .cpu_halt(cpu_halt),
      .ram_write_block(ram_write_block), .osc_stop(osc_stop), .ale_out(ale_out),
      .program_store_strobe(program_store_strobe), .port0_float(port0_float), .port2_address(port2_address));

   src_model u_src_model (.hclk(hclk), .pin_a(pin_a), .pin_b(pin_b), .t0_ovf(t0), .t1_ovf(t1),
      .t2_ovf(t2), .ser_req(ser), .trig_pin(trig));

   // ------------------------------------------------------------
   // clock, report and shared helpers
   // ------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end

   task report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task timeout(input string what);
      n_fail++;
      $display("[ERR] %s expected event seen timeout", what);
      report_and_stop;
   endtask

   task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // one phase ends at the edge where hready is seen high; never assume a latency
   task wait_ready;
      int n;
      for (n = 0; n < 50; n++) begin
         @(posedge hclk);
         if (hreadyout === 1'b1) break;
      end
      if (n == 50) timeout("hready");
   endtask

   // single word transfer; read data taken at the data phase's closing edge
   task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge hclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= a;
      hwrite <= w;
      wait_ready;
      hsel   <= 1'b0;
      htrans <= 2'b00;
      hwdata <= wd;
      wait_ready;
      rdata = hrdata;
   endtask

   task rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0000_0000);
      chk(what, exp, rdata);
   endtask

   // requests update once per machine cycle, so allow several cycles
   task wait_irq(input logic [5:0] exp);
      int n;
      for (n = 0; n < 150; n++) begin
         @(negedge hclk);
         if (irq_req === exp) break;
      end
      if (n == 150) timeout("irq_req");
      chk("irq_req", {26'h0, exp}, {26'h0, irq_req});
   endtask

   // reset for 10 cycles, then time the ram write guard window
   task do_reset;
      int n;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      for (n = 0; n < 100 && ram_write_block === 1'b1; n++) @(negedge hclk);
      chk("guard_ok", 32'h1, {31'h0, n >= 46 && n <= 50});
      chk("pins", 32'h3, {30'h0, ale_out, program_store_strobe});
      chk("halt_stop", 32'h0, {30'h0, cpu_halt, osc_stop});
      chk("irq_req", 32'h0, {26'h0, irq_req});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task t_enable_reg;
      rd_chk("ie_reset", `OFS_INTERRUPT_ENABLE, 32'h0000_0000);
      bus(1'b1, `OFS_INTERRUPT_ENABLE, 32'h0000_00BF);
      rd_chk("ie_rsvd", `OFS_INTERRUPT_ENABLE, 32'h0000_00BF);
      bus(1'b1, `OFS_INTERRUPT_ENABLE, 32'h0000_0000);
      rd_chk("unmapped", 8'h10, 32'h0000_0000);
   endtask

   // each source alone, then global off, then every other enable on
   task t_gating;
      logic [7:0] m;
      for (int i = 0; i < 6; i++) begin
         m = 8'h01 << i;
         bus(1'b1, `OFS_INTERRUPT_ENABLE, {24'h0, 8'h80 | m});
         u_src_model.raise(i);
         wait_irq(m[5:0]);
         bus(1'b1, `OFS_INTERRUPT_ENABLE, {24'h0, m});
         wait_irq(6'h00);
         bus(1'b1, `OFS_INTERRUPT_ENABLE, {24'h0, 8'h80 | (~m & 8'h3F)});
         repeat (30) @(posedge hclk);
         wait_irq(6'h00);
         u_src_model.drop_all;
         bus(1'b1, `OFS_FLAGS, 32'h0000_0000);
      end
   endtask

   // timer 2 event flag, OR with overflow, flags survive the acknowledge
   task t_timer2;
      bus(1'b1, `OFS_INTERRUPT_ENABLE, 32'h0000_00A0);
      u_src_model.trig_fall;
      repeat (30) @(negedge hclk);
      rd_chk("flags", `OFS_FLAGS, 32'h0000_0000);
      bus(1'b1, `OFS_FLAGS, 32'h0000_0010);
      u_src_model.trig_fall;
      wait_irq(6'h20);
      rd_chk("flags", `OFS_FLAGS, 32'h0000_0018);
      u_src_model.raise(5);
      // overflow flag lands at its set phase, up to one machine cycle later
      repeat (30) @(posedge hclk);
      irq_ack <= 1'b1;
      @(posedge hclk);
      irq_ack <= 1'b0;
      rd_chk("flags", `OFS_FLAGS, 32'h0000_001C);
      bus(1'b1, `OFS_FLAGS, 32'h0000_0010);
      wait_irq(6'h00);
      bus(1'b1, `OFS_FLAGS, 32'h0000_0000);
   endtask

   // idle with internal and external program memory, left by a timer 0 request
   task t_idle;
      int n;
      for (int e = 0; e < 2; e++) begin
         ext_program_mem <= e[0];
         bus(1'b1, `OFS_INTERRUPT_ENABLE, 32'h0000_0082);
         bus(1'b1, `OFS_POWER_CTRL, 32'h0000_0001);
         rd_chk("ie_held", `OFS_INTERRUPT_ENABLE, 32'h0000_0082);
         @(negedge hclk);
         chk("idle_pins", {28'h0, 2'b11, e[0], e[0]},
             {28'h0, ale_out, program_store_strobe, port0_float, port2_address});
         chk("idle_halt", 32'h2, {30'h0, cpu_halt, osc_stop});
         u_src_model.raise(1);
         for (n = 0; n < 100 && cpu_halt !== 1'b0; n++) @(negedge hclk);
         if (n == 100) timeout("idle exit");
         wait_irq(6'h02);
         bus(1'b1, `OFS_FLAGS, 32'h0000_0000);
      end
      // a reset also ends idle; the next access is a register read, never a port write
      bus(1'b1, `OFS_POWER_CTRL, 32'h0000_0001);
      rd_chk("ie_held", `OFS_INTERRUPT_ENABLE, 32'h0000_0082);
      do_reset;
   endtask

   // power-down ignores an enabled request and leaves only through reset
   task t_pdown;
      ext_program_mem <= 1'b1;
      bus(1'b1, `OFS_INTERRUPT_ENABLE, 32'h0000_0090);
      bus(1'b1, `OFS_POWER_CTRL, 32'h0000_0002);
      u_src_model.raise(4);
      repeat (80) @(negedge hclk);
      chk("pd_pins", 32'h2, {28'h0, ale_out, program_store_strobe, port0_float, port2_address});
      chk("pd_halt", 32'h3, {30'h0, cpu_halt, osc_stop});
      chk("pd_irq", 32'h0, {26'h0, irq_req});
      do_reset;
      rd_chk("ie_reinit", `OFS_INTERRUPT_ENABLE, 32'h0000_0000);
      u_src_model.drop_all;
   endtask

   // ------------------------------------------------------------
   // main sequence and run limit
   // ------------------------------------------------------------
   initial begin
      hresetn         = 1'b0;
      hsel            = 1'b0;
      haddr           = 8'h00;
      htrans          = 2'b00;
      hwrite          = 1'b0;
      hsize           = 3'b010;
      hwdata          = 32'h0000_0000;
      irq_ack         = 1'b0;
      ext_program_mem = 1'b0;
      n_fail          = 0;
      cmp_count       = 0;
      do_reset;
      t_enable_reg;
      t_gating;
      t_timer2;
      t_idle;
      t_pdown;
      report_and_stop;
   end

   initial begin
      repeat (100000) @(posedge hclk);
      timeout("run");
   end
endmodule
